// [pkg/tap_sleep_pkg.sv]
// Constants and types for the tap detection and autosleep logic
package tap_sleep_pkg;
  localparam logic [7:0] ADDR_TAP_THRESHOLD = 8'h1D;
  localparam logic [7:0] ADDR_TAP_DURATION = 8'h21;
  localparam logic [7:0] ADDR_TAP_LATENCY = 8'h22;
  localparam logic [7:0] ADDR_TAP_WINDOW = 8'h23;
  localparam logic [7:0] ADDR_TAP_AXES = 8'h2A;
  localparam logic [7:0] ADDR_MOTION_STATUS = 8'h2B;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h2D;
  localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h2E;
  localparam logic [7:0] ADDR_EVENT_ROUTE = 8'h2F;
  localparam logic [7:0] ADDR_EVENT_SOURCE = 8'h30;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Event bit positions, shared by enable, route and source
  localparam int BIT_SINGLE = 6;
  localparam int BIT_DOUBLE = 5;
  localparam int BIT_ACT = 4;
  localparam int BIT_INACT = 3;
  localparam int BIT_FFALL = 2;
  // Tap axes control fields
  localparam int BIT_SUPPRESS = 3;
  // Motion status field
  localparam int BIT_ASLEEP = 3;
  // Power control fields
  localparam int BIT_LINK = 5;
  localparam int BIT_AUTOSLEEP = 4;
  localparam int BIT_SLEEP = 2;
  // Timing: one timing step is one internal sample tick
  localparam int SAMPLE_PERIOD_NS = 1000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SAMPLE_DIV = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SLEEP_DECIM = 8;
  typedef enum logic [2:0] {
    TAP_IDLE = 3'b000,
    TAP_FIRST = 3'b001,
    TAP_LATENCY = 3'b010,
    TAP_WINDOW = 3'b011,
    TAP_SECOND = 3'b100
  } tap_state_t;
endpackage

// [core/tap_detect_autosleep.sv]
// Tap detection, link mode and autosleep event logic with its registers
`timescale 1ns/100ps
// Summary of operation
// - Tap in progress while a participating axis exceeds the tap threshold.
// - Duration register is the longest above-threshold time for a valid tap.
// - After first tap ends, wait latency before opening the second-tap window.
// - Second tap must start after latency, inside window; may end after it.
// - Single-tap only: event as acceleration falls below threshold within duration.
// - Both enabled: single event waits until double is validated or invalidated.
// - Suppress bit set: above-threshold during latency cancels double tap.
// - Above threshold as window opens invalidates double tap.
// - Second tap exceeding duration invalidates double tap at duration end.
// - Enable bits select single, double or both tap detection.
// - Each axis joins tap detection only when its axis bit is set.
// - Double tap works only with nonzero latency and window.
// - Tap event records first axis over threshold; overwritten, never cleared.
// - Detection uses undecimated samples; lower rates decimate the common stream.
// - Link set: activity and inactivity detection alternate.
// - Host clears events by reading source; no autosleep while activity pending.
// - Asleep bit of motion status shows current sleep state.
// - Low power mode keeps sample-ready running.
// - Inactivity with sleep, autosleep, link: go to sleep, arm activity only.
// - Activity while asleep: restore rate, raise activity, arm inactivity only.
// - Reading the source register clears tap, activity, inactivity, free-fall.
// - Route bit 0 sends an event to line one, 1 to line two; ORed.
module tap_detect_autosleep (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [15:0] accel_x_in,
  input wire logic [15:0] accel_y_in,
  input wire logic [15:0] accel_z_in,
  input wire logic activity_in,
  input wire logic inactivity_in,
  input wire logic free_fall_in,
  output logic sample_tick_out,
  output logic output_tick_out,
  output logic low_rate_out,
  output logic irq_line_one_out,
  output logic irq_line_two_out
);
  import tap_sleep_pkg::*;

  logic [7:0] threshold_q, duration_q, latency_q, window_q, axes_q;
  logic [7:0] power_q, enable_q, route_q, source_q, motion_q;
  logic [15:0] div_q;
  logic tick_q;
  logic [3:0] decim_q;
  logic [7:0] timer_q;
  logic [2:0] first_axes_q;
  logic [2:0] tap_axes_q;
  logic single_pend_q, was_over_q;
  logic asleep_q;
  logic arm_act_q, arm_inact_q;
  logic [2:0] act_sync1_q, act_sync2_q;
  logic [15:0] ax_sync1_q, ay_sync1_q, az_sync1_q;
  logic [15:0] ax_q, ay_q, az_q;
  tap_state_t state_q;
  logic [2:0] over;
  logic any_over;
  logic double_on;
  logic single_ev, double_ev, act_ev, inact_ev;
  logic src_read;

  // Magnitude against threshold per axis, masked by participation
  function automatic logic exceeds(input logic [15:0] v, input logic [7:0] th);
    logic [15:0] mag;
    mag = v[15] ? 16'(-v) : v;
    exceeds = mag > {8'h00, th};
  endfunction

  always_comb
  begin
    over[2] = axes_q[2] && exceeds(ax_q, threshold_q);
    over[1] = axes_q[1] && exceeds(ay_q, threshold_q);
    over[0] = axes_q[0] && exceeds(az_q, threshold_q);
    any_over = |over;
    double_on = enable_q[BIT_DOUBLE] && latency_q != RESET_BYTE
      && window_q != RESET_BYTE;
  end

  assign src_read = reg_rd_in && reg_addr_in == ADDR_EVENT_SOURCE;

  // Pin inputs pass two flip-flops before use
  always_ff @(posedge clk_in)
  begin
    ax_sync1_q <= accel_x_in;
    ay_sync1_q <= accel_y_in;
    az_sync1_q <= accel_z_in;
    ax_q <= ax_sync1_q;
    ay_q <= ay_sync1_q;
    az_q <= az_sync1_q;
    act_sync1_q <= {activity_in, inactivity_in, free_fall_in};
    act_sync2_q <= act_sync1_q;
  end

  // Sample tick paces detection; output rate is decimated when asleep
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      div_q <= '0;
      tick_q <= 1'b0;
      decim_q <= '0;
      output_tick_out <= 1'b0;
      sample_tick_out <= 1'b0;
    end
    else
    begin
      tick_q <= div_q == 16'(SAMPLE_DIV - 1);
      div_q <= (div_q == 16'(SAMPLE_DIV - 1)) ? '0 : div_q + 16'h0001;
      sample_tick_out <= div_q == 16'(SAMPLE_DIV - 1);
      if (tick_q)
        decim_q <= (decim_q == 4'(SLEEP_DECIM - 1)) ? '0 : decim_q + 4'h1;
      // Low power mode keeps the sample-ready stream alive
      output_tick_out <= tick_q && (!asleep_q || decim_q == '0);
    end
  end

  // Register writes
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      threshold_q <= RESET_BYTE;
      duration_q <= RESET_BYTE;
      latency_q <= RESET_BYTE;
      window_q <= RESET_BYTE;
      axes_q <= RESET_BYTE;
      power_q <= RESET_BYTE;
      enable_q <= RESET_BYTE;
      route_q <= RESET_BYTE;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        ADDR_TAP_THRESHOLD: threshold_q <= reg_wdata_in;
        ADDR_TAP_DURATION: duration_q <= reg_wdata_in;
        ADDR_TAP_LATENCY: latency_q <= reg_wdata_in;
        ADDR_TAP_WINDOW: window_q <= reg_wdata_in;
        ADDR_TAP_AXES: axes_q <= reg_wdata_in;
        ADDR_POWER_CTRL: power_q <= reg_wdata_in;
        ADDR_EVENT_ENABLE: enable_q <= reg_wdata_in;
        ADDR_EVENT_ROUTE: route_q <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Tap state machine, stepped on each sample tick
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_q <= TAP_IDLE;
      timer_q <= '0;
      first_axes_q <= '0;
      tap_axes_q <= '0;
      single_pend_q <= 1'b0;
      was_over_q <= 1'b0;
      single_ev <= 1'b0;
      double_ev <= 1'b0;
    end
    else
    begin
      single_ev <= 1'b0;
      double_ev <= 1'b0;
      if (tick_q)
      begin
        // Long or cancelled spikes must fall before a new tap can start
        was_over_q <= any_over;
        case (state_q)
          TAP_IDLE:
          begin
            if (any_over && !was_over_q && (enable_q[BIT_SINGLE] || double_on))
            begin
              state_q <= TAP_FIRST;
              timer_q <= 8'h01;
              first_axes_q <= over;
            end
          end
          TAP_FIRST:
          begin
            if (!any_over)
            begin
              if (double_on)
              begin
                state_q <= TAP_LATENCY;
                single_pend_q <= enable_q[BIT_SINGLE];
                timer_q <= 8'h01;
              end
              else
              begin
                single_ev <= 1'b1;
                tap_axes_q <= first_axes_q;
                state_q <= TAP_IDLE;
              end
            end
            else if (timer_q >= duration_q)
              state_q <= TAP_IDLE;
            else
              timer_q <= timer_q + 8'h01;
          end
          TAP_LATENCY:
          begin
            if (any_over && axes_q[BIT_SUPPRESS])
            begin
              single_ev <= single_pend_q;
              tap_axes_q <= first_axes_q;
              single_pend_q <= 1'b0;
              state_q <= TAP_IDLE;
            end
            else if (timer_q >= latency_q)
            begin
              if (any_over)
              begin
                single_ev <= single_pend_q;
                tap_axes_q <= first_axes_q;
                single_pend_q <= 1'b0;
                state_q <= TAP_IDLE;
              end
              else
              begin
                state_q <= TAP_WINDOW;
                timer_q <= 8'h01;
              end
            end
            else
              timer_q <= timer_q + 8'h01;
          end
          TAP_WINDOW:
          begin
            if (any_over)
            begin
              state_q <= TAP_SECOND;
              timer_q <= 8'h01;
            end
            else if (timer_q >= window_q)
            begin
              single_ev <= single_pend_q;
              tap_axes_q <= first_axes_q;
              single_pend_q <= 1'b0;
              state_q <= TAP_IDLE;
            end
            else
              timer_q <= timer_q + 8'h01;
          end
          TAP_SECOND:
          begin
            if (!any_over)
            begin
              double_ev <= 1'b1;
              single_ev <= single_pend_q;
              tap_axes_q <= first_axes_q;
              single_pend_q <= 1'b0;
              state_q <= TAP_IDLE;
            end
            else if (timer_q >= duration_q)
            begin
              single_ev <= single_pend_q;
              tap_axes_q <= first_axes_q;
              single_pend_q <= 1'b0;
              state_q <= TAP_IDLE;
            end
            else
              timer_q <= timer_q + 8'h01;
          end
          default: state_q <= TAP_IDLE;
        endcase
      end
    end
  end

  // Activity arming follows link mode; without link both stay armed
  always_comb
  begin
    act_ev = act_sync2_q[2] && (arm_act_q || !power_q[BIT_LINK]) && enable_q[BIT_ACT];
    inact_ev = act_sync2_q[1] && (arm_inact_q || !power_q[BIT_LINK])
      && enable_q[BIT_INACT];
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      arm_act_q <= 1'b1;
      arm_inact_q <= 1'b1;
      asleep_q <= 1'b0;
    end
    else if (!power_q[BIT_LINK])
    begin
      arm_act_q <= 1'b1;
      arm_inact_q <= 1'b1;
      asleep_q <= 1'b0;
    end
    else if (act_ev)
    begin
      arm_act_q <= 1'b0;
      arm_inact_q <= 1'b1;
      asleep_q <= 1'b0;
    end
    else if (inact_ev)
    begin
      arm_act_q <= 1'b1;
      arm_inact_q <= 1'b0;
      // Pending activity blocks autosleep
      if (power_q[BIT_SLEEP] && power_q[BIT_AUTOSLEEP] && !source_q[BIT_ACT])
        asleep_q <= 1'b1;
    end
  end

  // Event flags: a new event in the read cycle wins over the clear
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      source_q <= RESET_BYTE;
    else
    begin
      if (src_read)
        source_q <= RESET_BYTE;
      if (single_ev && enable_q[BIT_SINGLE])
        source_q[BIT_SINGLE] <= 1'b1;
      if (double_ev)
        source_q[BIT_DOUBLE] <= 1'b1;
      if (act_ev)
        source_q[BIT_ACT] <= 1'b1;
      if (inact_ev)
        source_q[BIT_INACT] <= 1'b1;
      if (act_sync2_q[0] && enable_q[BIT_FFALL])
        source_q[BIT_FFALL] <= 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      motion_q <= RESET_BYTE;
    else
      motion_q <= {4'h0, asleep_q, tap_axes_q};
  end

  // Read data and interrupt lines
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      reg_rdata_out <= RESET_BYTE;
      irq_line_one_out <= 1'b0;
      irq_line_two_out <= 1'b0;
      low_rate_out <= 1'b0;
    end
    else
    begin
      irq_line_one_out <= |(source_q & enable_q & ~route_q);
      irq_line_two_out <= |(source_q & enable_q & route_q);
      low_rate_out <= asleep_q;
      if (reg_rd_in)
      begin
        case (reg_addr_in)
          ADDR_TAP_THRESHOLD: reg_rdata_out <= threshold_q;
          ADDR_TAP_DURATION: reg_rdata_out <= duration_q;
          ADDR_TAP_LATENCY: reg_rdata_out <= latency_q;
          ADDR_TAP_WINDOW: reg_rdata_out <= window_q;
          ADDR_TAP_AXES: reg_rdata_out <= axes_q;
          ADDR_MOTION_STATUS: reg_rdata_out <= motion_q;
          ADDR_POWER_CTRL: reg_rdata_out <= power_q;
          ADDR_EVENT_ENABLE: reg_rdata_out <= enable_q;
          ADDR_EVENT_ROUTE: reg_rdata_out <= route_q;
          ADDR_EVENT_SOURCE: reg_rdata_out <= source_q;
          default: reg_rdata_out <= RESET_BYTE;
        endcase
      end
    end
  end
endmodule

// [tb/tap_detect_autosleep_props.sv]
// Checker bound to the tap and autosleep block
`timescale 1ns/100ps
module tap_detect_autosleep_props (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic activity_in,
  input wire logic inactivity_in,
  input wire logic sample_tick_out,
  input wire logic output_tick_out,
  input wire logic low_rate_out,
  input wire logic irq_line_one_out,
  input wire logic irq_line_two_out
);
  import tap_sleep_pkg::*;
  logic [7:0] en_q, route_q;
  logic seen_q;
  logic [3:0] age_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge clk_in)
    if (rst_in) en_q <= RESET_BYTE;
    else if (reg_wr_in && reg_addr_in == ADDR_EVENT_ENABLE) en_q <= reg_wdata_in;
  always_ff @(posedge clk_in)
    if (rst_in) route_q <= RESET_BYTE;
    else if (reg_wr_in && reg_addr_in == ADDR_EVENT_ROUTE) route_q <= reg_wdata_in;
  // Sticky: once link was set, sleep is legal
  always_ff @(posedge clk_in)
    if (rst_in) seen_q <= 1'b0;
    else if (reg_wr_in && reg_addr_in == ADDR_POWER_CTRL && reg_wdata_in[BIT_LINK]) seen_q <= 1'b1;
  // Age of the last cause of a sleep change, saturating
  always_ff @(posedge clk_in)
    if (rst_in || activity_in || inactivity_in || reg_wr_in || reg_rd_in) age_q <= 4'h0;
    else if (age_q != 4'hF) age_q <= age_q + 4'h1;
  a_tick_period: assert property (sample_tick_out |-> ##125 sample_tick_out)
    else $error("sample tick period wrong");
  a_tick_gap: assert property (sample_tick_out |=> (!sample_tick_out) [*8])
    else $error("sample tick too soon");
  a_awake_rate: assert property (sample_tick_out && !low_rate_out && !$past(low_rate_out)
    |=> output_tick_out || low_rate_out)
    else $error("output tick missing while awake");
  a_sleep_rate: assert property (output_tick_out && low_rate_out |=> (!output_tick_out) [*8])
    else $error("output tick not decimated asleep");
  a_rdata_stands: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  a_no_link_sleep: assert property (!seen_q |-> !low_rate_out)
    else $error("asleep without link");
  a_sleep_cause: assert property ($rose(low_rate_out) || $fell(low_rate_out) |-> age_q != 4'hF)
    else $error("sleep state changed without cause");
  a_irq_masked: assert property (en_q == 8'h00 && $past(en_q) == 8'h00 && $past(en_q, 2) == 8'h00
    |-> !irq_line_one_out && !irq_line_two_out)
    else $error("event line high with all events disabled");
  a_route_one: assert property (route_q[6:2] == 5'h00 && $past(route_q[6:2]) == 5'h00
    |-> !irq_line_two_out)
    else $error("line two high with all events on line one");
endmodule
bind tap_detect_autosleep tap_detect_autosleep_props chk (.clk_in, .rst_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .activity_in, .inactivity_in,
  .sample_tick_out, .output_tick_out, .low_rate_out, .irq_line_one_out, .irq_line_two_out);

// [tb/host_model.sv]
// Host model: register bus master and event line watcher
`timescale 1ns/100ps
module host_model (
  input wire logic clk_in,
  input wire logic irq_one_in,
  input wire logic irq_two_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  logic [7:0] exp_q [$];
  initial
  begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // Released bus shows inverted values, never the last ones
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    exp_q.push_back(e);
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
  endtask
  task automatic wait_irq(output logic [7:0] got);
    int n;
    n = 0;
    got = 8'h00;
    while (got == 8'h00 && n < 2000)
    begin
      @(negedge clk_in);
      got = {6'h00, irq_two_in, irq_one_in};
      n++;
    end
  endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the tap and autosleep block
`timescale 1ns/100ps
module testbench;
  import tap_sleep_pkg::*;
  logic clk_in, rst_in, reg_wr_in, reg_rd_in, activity_in, inactivity_in, free_fall_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, d, got;
  logic [15:0] accel_x_in, accel_y_in, accel_z_in;
  logic sample_tick_out, output_tick_out, low_rate_out, irq_line_one_out, irq_line_two_out;
  logic pend_q;
  logic [31:0] rnd = 32'h20;
  int num_errors, tests_run, cycles;
  logic [7:0] rw_addr [6];
  tap_detect_autosleep DUT (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .accel_x_in, .accel_y_in, .accel_z_in, .activity_in,
    .inactivity_in, .free_fall_in, .sample_tick_out, .output_tick_out, .low_rate_out,
    .irq_line_one_out, .irq_line_two_out);
  host_model host (.clk_in, .irq_one_in(irq_line_one_out), .irq_two_in(irq_line_two_out),
    .addr_out(reg_addr_in), .wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
    tests_run++;
    if (seen_v !== exp_v)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n * SAMPLE_DIV) @(negedge clk_in);
  endtask
  // Negative sample tests the magnitude compare
  task automatic tap(input int n);
    @(negedge clk_in);
    accel_x_in = 16'hFF00;
    ticks(n);
    accel_x_in = 16'h0000;
  endtask
  task automatic pulse(input logic act);
    @(negedge clk_in);
    activity_in = act;
    inactivity_in = !act;
    repeat (4) @(negedge clk_in);
    activity_in = 1'b0;
    inactivity_in = 1'b0;
    repeat (12) @(negedge clk_in);
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    pend_q <= reg_rd_in;
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      close_out;
    end
  end
  always @(negedge clk_in)
    if (pend_q) check(reg_rdata_out, host.exp_q.pop_front());
  // Idle noise on y and z stays below any threshold used
  always @(negedge clk_in)
  begin
    rnd = xs(rnd);
    accel_y_in = {12'h000, rnd[3:0]};
    accel_z_in = {12'h000, rnd[7:4]};
  end
  initial
  begin
    rst_in = 1'b1;
    {activity_in, inactivity_in, free_fall_in, pend_q} = 4'h0;
    {accel_x_in, accel_y_in, accel_z_in} = 48'h0;
    {num_errors, tests_run, cycles} = 96'h0;
    rw_addr = '{ADDR_TAP_THRESHOLD, ADDR_TAP_DURATION, ADDR_TAP_LATENCY, ADDR_TAP_WINDOW,
      ADDR_TAP_AXES, ADDR_EVENT_ENABLE};
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    foreach (rw_addr[i])
    begin
      d = rnd[15:8] | 8'h10;
      host.rd_reg(rw_addr[i], RESET_BYTE);
      host.wr_reg(rw_addr[i], d);
      host.rd_reg(rw_addr[i], d);
    end
    host.wr_reg(ADDR_MOTION_STATUS, 8'hFF);
    host.rd_reg(ADDR_MOTION_STATUS, 8'h00);
    host.rd_reg(8'h00, 8'h00);
    host.rd_reg(ADDR_EVENT_SOURCE, 8'h00);
    host.wr_reg(ADDR_TAP_THRESHOLD, 8'h31);
    host.wr_reg(ADDR_TAP_DURATION, 8'h11);
    host.wr_reg(ADDR_TAP_LATENCY, 8'h11);
    host.wr_reg(ADDR_TAP_WINDOW, 8'h41);
    host.wr_reg(ADDR_TAP_AXES, 8'h04);
    host.wr_reg(ADDR_EVENT_ROUTE, 8'h40);
    host.wr_reg(ADDR_EVENT_ENABLE, 8'h40);
    tap(4);
    host.wait_irq(got);
    check(got, 8'h02);
    host.rd_reg(ADDR_EVENT_SOURCE, 8'h40);
    host.rd_reg(ADDR_MOTION_STATUS, 8'h04);
    repeat (3) @(negedge clk_in);
    check({6'h00, irq_line_two_out, irq_line_one_out}, 8'h00);
    host.wr_reg(ADDR_EVENT_ROUTE, 8'h00);
    host.wr_reg(ADDR_TAP_AXES, 8'h03);
    tap(4);
    ticks(2);
    host.rd_reg(ADDR_EVENT_SOURCE, 8'h00);
    host.wr_reg(ADDR_TAP_AXES, 8'h04);
    tap(24);
    ticks(2);
    host.rd_reg(ADDR_EVENT_SOURCE, 8'h00);
    host.wr_reg(ADDR_EVENT_ENABLE, 8'h60);
    tap(4);
    ticks(20);
    host.rd_reg(ADDR_EVENT_SOURCE, 8'h00);
    ticks(4);
    tap(4);
    ticks(3);
    host.rd_reg(ADDR_EVENT_SOURCE, 8'h60);
    host.wr_reg(ADDR_TAP_AXES, 8'h0C);
    tap(4);
    ticks(4);
    tap(2);
    ticks(6);
    host.rd_reg(ADDR_EVENT_SOURCE, 8'h40);
    host.wr_reg(ADDR_TAP_LATENCY, 8'h00);
    ticks(2);
    tap(4);
    ticks(2);
    host.rd_reg(ADDR_EVENT_SOURCE, 8'h40);
    host.wr_reg(ADDR_EVENT_ENABLE, 8'h18);
    host.wr_reg(ADDR_POWER_CTRL, 8'h34);
    pulse(1'b0);
    check({7'h00, low_rate_out}, 8'h01);
    host.rd_reg(ADDR_EVENT_SOURCE, 8'h08);
    host.rd_reg(ADDR_MOTION_STATUS, 8'h0C);
    ticks(10);
    pulse(1'b0);
    pulse(1'b1);
    check({7'h00, low_rate_out}, 8'h00);
    host.rd_reg(ADDR_EVENT_SOURCE, 8'h10);
    pulse(1'b1);
    host.rd_reg(ADDR_EVENT_SOURCE, 8'h00);
    host.wr_reg(ADDR_POWER_CTRL, 8'h14);
    pulse(1'b1);
    host.wr_reg(ADDR_POWER_CTRL, 8'h34);
    pulse(1'b0);
    check({7'h00, low_rate_out}, 8'h00);
    host.rd_reg(ADDR_EVENT_SOURCE, 8'h18);
    host.wr_reg(ADDR_EVENT_ENABLE, 8'h04);
    @(negedge clk_in);
    free_fall_in = 1'b1;
    host.wait_irq(got);
    free_fall_in = 1'b0;
    check(got, 8'h01);
    repeat (4) @(negedge clk_in);
    host.rd_reg(ADDR_EVENT_SOURCE, 8'h04);
    host.rd_reg(ADDR_EVENT_SOURCE, 8'h00);
    close_out;
  end
endmodule
